// ### verilog/phc_codec.sv
// Header-encoded packet codec with AXI4-Lite control registers
`timescale 1ns/1ps
// What this block does
// - Beats move only when valid and ready are both high.
// - Final beat of every packet carries the last-beat flag.
// - Each beat carries data with byte enables.
// - Header occupies its own beat; payload follows in separate beats.
// - Common header fields share bit positions across all classes.
// - Transaction tag sits in header bits 63 to 56.
// - Four-bit class code sits in bits 55 to 52.
// - Only classes 2, 5, 6, A, B, D accepted on the request path; build may narrow.
// - Subtype in bits 51 to 48 used only for classes 2, 5, 13.
// - Bit 44 carries the critical flow flag.
// - Bits 43 to 36 hold payload byte count minus one.
// - Error bit 35 meaningful only for responses, else zero.
// - Received response status DONE clears error bit, any other sets it.
// - Responses: class 1101, subtype 0000, 1000 or 0001.
// - Read and write classes carry byte address in bits 33 to 0.
// - Messages: segment count and index minus one in top nibbles.
// - Messages: mailbox in bits 9 to 4, letter in bits 1 to 0.
module phc_codec #(
  parameter logic [5:0] CLASS_BUILD = 6'h3F
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [31:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [31:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire logic [63:0] s_req_tdata,
  input wire logic [7:0] s_req_tkeep,
  input wire logic s_req_tlast,
  input wire logic s_req_tvalid,
  output logic s_req_tready,
  output logic [63:0] c_req_tdata,
  output logic [7:0] c_req_tkeep,
  output logic c_req_tlast,
  output logic c_req_header,
  output logic c_req_tvalid,
  input wire logic c_req_tready,
  output logic [7:0] c_req_tag,
  output logic [3:0] c_req_class,
  output logic [3:0] c_req_subtype,
  output logic [1:0] c_req_prio,
  output logic c_req_crf,
  output logic [7:0] c_req_size,
  output logic [33:0] c_req_addr,
  input wire logic c_rsp_valid,
  output logic c_rsp_ready,
  input wire logic [7:0] c_rsp_tag,
  input wire logic [3:0] c_rsp_class,
  input wire logic [3:0] c_rsp_subtype,
  input wire logic [1:0] c_rsp_prio,
  input wire logic c_rsp_crf,
  input wire logic [7:0] c_rsp_size,
  input wire logic [3:0] c_rsp_status,
  input wire logic [33:0] c_rsp_addr,
  input wire logic [3:0] c_rsp_msg_len,
  input wire logic [3:0] c_rsp_msg_seg,
  input wire logic [5:0] c_rsp_mailbox,
  input wire logic [1:0] c_rsp_letter,
  input wire logic c_rsp_has_data,
  input wire logic [63:0] c_rsp_ddata,
  input wire logic [7:0] c_rsp_dkeep,
  input wire logic c_rsp_dlast,
  input wire logic c_rsp_dvalid,
  output logic c_rsp_dready,
  output logic [63:0] m_rsp_tdata,
  output logic [7:0] m_rsp_tkeep,
  output logic m_rsp_tlast,
  output logic m_rsp_tvalid,
  input wire logic m_rsp_tready
);
  function automatic logic class_ok(input logic [3:0] cls, input logic [5:0] mask);
    logic ok;
    ok = 1'b0;
    case (cls)
      phc_pkg::CLS_READ: ok = mask[0];
      phc_pkg::CLS_WRITE: ok = mask[1];
      phc_pkg::CLS_SWRITE: ok = mask[2];
      phc_pkg::CLS_DBELL: ok = mask[3];
      phc_pkg::CLS_MSG: ok = mask[4];
      phc_pkg::CLS_RESP: ok = mask[5];
      default: ok = 1'b0;
    endcase
    return ok;
  endfunction

  function automatic logic has_subtype(input logic [3:0] cls);
    return cls == phc_pkg::CLS_READ || cls == phc_pkg::CLS_WRITE || cls == phc_pkg::CLS_RESP;
  endfunction

  // ---------------- Register bus ----------------
  logic aw_have_r, aw_have_nxt, w_have_r, w_have_nxt;
  logic [3:0] aw_ofs_r, aw_ofs_nxt;
  logic [31:0] wdata_r, wdata_nxt;
  logic [3:0] wstrb_r, wstrb_nxt;
  logic bvalid_r, bvalid_nxt, rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic [5:0] ctrl_r, ctrl_nxt;
  logic [15:0] drop_cnt_r, drop_cnt_nxt, prio_cnt_r, prio_cnt_nxt;
  logic [15:0] tx_cnt_r, tx_cnt_nxt, rx_cnt_r, rx_cnt_nxt;
  logic bus_hit;
  logic tx_pkt_done, tx_drop_done, tx_bad_prio, rx_hdr_take;

  always_comb begin
    aw_have_nxt = aw_have_r;
    w_have_nxt = w_have_r;
    aw_ofs_nxt = aw_ofs_r;
    wdata_nxt = wdata_r;
    wstrb_nxt = wstrb_r;
    bvalid_nxt = bvalid_r;
    bresp_nxt = bresp_r;
    rvalid_nxt = rvalid_r;
    rresp_nxt = rresp_r;
    rdata_nxt = rdata_r;
    ctrl_nxt = ctrl_r;
    bus_hit = 1'b0;
    if (s_axi_awvalid && !aw_have_r) begin
      aw_have_nxt = 1'b1;
      aw_ofs_nxt = s_axi_awaddr[3:0];
    end
    if (s_axi_wvalid && !w_have_r) begin
      w_have_nxt = 1'b1;
      wdata_nxt = s_axi_wdata;
      wstrb_nxt = s_axi_wstrb;
    end
    if (aw_have_r && w_have_r && !bvalid_r) begin
      bus_hit = aw_ofs_r == phc_pkg::OFS_CTRL;
      if (bus_hit && wstrb_r[0]) begin
        ctrl_nxt = wdata_r[5:0] & CLASS_BUILD;
      end
      bvalid_nxt = 1'b1;
      bresp_nxt = bus_hit ? phc_pkg::RESP_OKAY : phc_pkg::RESP_SLVERR;
      aw_have_nxt = 1'b0;
      w_have_nxt = 1'b0;
    end else if (bvalid_r && s_axi_bready) begin
      bvalid_nxt = 1'b0;
    end
    if (s_axi_arvalid && !rvalid_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = phc_pkg::RESP_OKAY;
      case (s_axi_araddr[3:0])
        phc_pkg::OFS_CTRL: rdata_nxt = {26'h0, ctrl_r};
        phc_pkg::OFS_ERRCNT: rdata_nxt = {prio_cnt_r, drop_cnt_r};
        phc_pkg::OFS_PKTCNT: rdata_nxt = {rx_cnt_r, tx_cnt_r};
        default: begin
          rdata_nxt = 32'h00000000;
          rresp_nxt = phc_pkg::RESP_SLVERR;
        end
      endcase
    end else if (rvalid_r && s_axi_rready) begin
      rvalid_nxt = 1'b0;
    end
    drop_cnt_nxt = drop_cnt_r + 16'(tx_drop_done);
    prio_cnt_nxt = prio_cnt_r + 16'(tx_bad_prio);
    tx_cnt_nxt = tx_cnt_r + 16'(tx_pkt_done);
    rx_cnt_nxt = rx_cnt_r + 16'(rx_hdr_take);
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r <= 1'b0;
      aw_ofs_r <= 4'h0;
      wdata_r <= 32'h00000000;
      wstrb_r <= 4'h0;
      bvalid_r <= 1'b0;
      bresp_r <= 2'h0;
      rvalid_r <= 1'b0;
      rresp_r <= 2'h0;
      rdata_r <= 32'h00000000;
      ctrl_r <= phc_pkg::CTRL_RESET & CLASS_BUILD;
      drop_cnt_r <= 16'h0000;
      prio_cnt_r <= 16'h0000;
      tx_cnt_r <= 16'h0000;
      rx_cnt_r <= 16'h0000;
    end else begin
      aw_have_r <= aw_have_nxt;
      w_have_r <= w_have_nxt;
      aw_ofs_r <= aw_ofs_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      rvalid_r <= rvalid_nxt;
      rresp_r <= rresp_nxt;
      rdata_r <= rdata_nxt;
      ctrl_r <= ctrl_nxt;
      drop_cnt_r <= drop_cnt_nxt;
      prio_cnt_r <= prio_cnt_nxt;
      tx_cnt_r <= tx_cnt_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  assign s_axi_awready = !aw_have_r;
  assign s_axi_wready = !w_have_r;
  assign s_axi_bvalid = bvalid_r;
  assign s_axi_bresp = bresp_r;
  assign s_axi_arready = !rvalid_r;
  assign s_axi_rvalid = rvalid_r;
  assign s_axi_rresp = rresp_r;
  assign s_axi_rdata = rdata_r;

  // ---------------- Request path: user to core ----------------
  // One beat in flight; halves peak rate but keeps every output registered
  logic in_pkt_r, in_pkt_nxt, dropping_r, dropping_nxt;
  logic rdy_r, rdy_nxt, ov_r, ov_nxt, ohdr_r, ohdr_nxt, olast_r, olast_nxt;
  logic [63:0] odata_r, odata_nxt;
  logic [7:0] okeep_r, okeep_nxt;
  logic [7:0] tag_r, tag_nxt, size_r, size_nxt;
  logic [3:0] cls_r, cls_nxt, sub_r, sub_nxt;
  logic [1:0] pri_r, pri_nxt;
  logic crf_r, crf_nxt;
  logic [33:0] addr_r, addr_nxt;
  logic s_take, hdr_beat;
  logic [3:0] in_cls;

  always_comb begin
    in_pkt_nxt = in_pkt_r;
    dropping_nxt = dropping_r;
    ov_nxt = ov_r;
    ohdr_nxt = ohdr_r;
    olast_nxt = olast_r;
    odata_nxt = odata_r;
    okeep_nxt = okeep_r;
    tag_nxt = tag_r;
    cls_nxt = cls_r;
    sub_nxt = sub_r;
    pri_nxt = pri_r;
    crf_nxt = crf_r;
    size_nxt = size_r;
    addr_nxt = addr_r;
    tx_pkt_done = 1'b0;
    tx_drop_done = 1'b0;
    tx_bad_prio = 1'b0;
    s_take = s_req_tvalid && rdy_r;
    hdr_beat = !in_pkt_r;
    in_cls = s_req_tdata[phc_pkg::CLS_HI:phc_pkg::CLS_LO];
    if (ov_r && c_req_tready) begin
      ov_nxt = 1'b0;
    end
    if (s_take) begin
      in_pkt_nxt = !s_req_tlast;
      if (hdr_beat) begin
        dropping_nxt = !class_ok(in_cls, ctrl_r);
      end
      if ((hdr_beat && !class_ok(in_cls, ctrl_r)) || (!hdr_beat && dropping_r)) begin
        tx_drop_done = s_req_tlast;
      end else begin
        ov_nxt = 1'b1;
        ohdr_nxt = hdr_beat;
        olast_nxt = s_req_tlast;
        odata_nxt = s_req_tdata;
        okeep_nxt = s_req_tkeep;
        tx_pkt_done = s_req_tlast;
        if (hdr_beat) begin
          // Fields decoded from fixed positions, reserved bits never looked at
          tag_nxt = s_req_tdata[phc_pkg::TAG_HI:phc_pkg::TAG_LO];
          cls_nxt = in_cls;
          sub_nxt = has_subtype(in_cls) ? s_req_tdata[phc_pkg::SUB_HI:phc_pkg::SUB_LO] : 4'h0;
          pri_nxt = s_req_tdata[phc_pkg::PRI_HI:phc_pkg::PRI_LO];
          crf_nxt = s_req_tdata[phc_pkg::CRF_BIT];
          size_nxt = s_req_tdata[phc_pkg::SIZE_HI:phc_pkg::SIZE_LO];
          addr_nxt = s_req_tdata[phc_pkg::ADDR_HI:0];
          // Bad priority is counted, not blocked; the far end owns it
          tx_bad_prio = in_cls != phc_pkg::CLS_RESP &&
                        s_req_tdata[phc_pkg::PRI_HI:phc_pkg::PRI_LO] == phc_pkg::PRIO_ILLEGAL;
        end
      end
    end
    rdy_nxt = !ov_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      in_pkt_r <= 1'b0;
      dropping_r <= 1'b0;
      rdy_r <= 1'b0;
      ov_r <= 1'b0;
      ohdr_r <= 1'b0;
      olast_r <= 1'b0;
      odata_r <= 64'h0000000000000000;
      okeep_r <= 8'h00;
      tag_r <= 8'h00;
      cls_r <= 4'h0;
      sub_r <= 4'h0;
      pri_r <= 2'h0;
      crf_r <= 1'b0;
      size_r <= 8'h00;
      addr_r <= 34'h000000000;
    end else begin
      in_pkt_r <= in_pkt_nxt;
      dropping_r <= dropping_nxt;
      rdy_r <= rdy_nxt;
      ov_r <= ov_nxt;
      ohdr_r <= ohdr_nxt;
      olast_r <= olast_nxt;
      odata_r <= odata_nxt;
      okeep_r <= okeep_nxt;
      tag_r <= tag_nxt;
      cls_r <= cls_nxt;
      sub_r <= sub_nxt;
      pri_r <= pri_nxt;
      crf_r <= crf_nxt;
      size_r <= size_nxt;
      addr_r <= addr_nxt;
    end
  end

  assign s_req_tready = rdy_r;
  assign c_req_tvalid = ov_r;
  assign c_req_header = ohdr_r;
  assign c_req_tlast = olast_r;
  assign c_req_tdata = odata_r;
  assign c_req_tkeep = okeep_r;
  assign c_req_tag = tag_r;
  assign c_req_class = cls_r;
  assign c_req_subtype = sub_r;
  assign c_req_prio = pri_r;
  assign c_req_crf = crf_r;
  assign c_req_size = size_r;
  assign c_req_addr = addr_r;

  // ---------------- Receive path: core to user ----------------
  phc_pkg::phc_rx_state_t st_r, st_nxt;
  logic mv_r, mv_nxt, ml_r, ml_nxt, hrdy_r, hrdy_nxt, drdy_r, drdy_nxt;
  logic [63:0] md_r, md_nxt;
  logic [7:0] mk_r, mk_nxt;
  logic [63:0] hword;

  always_comb begin
    hword = 64'h0000000000000000;
    hword[phc_pkg::CLS_HI:phc_pkg::CLS_LO] = c_rsp_class;
    hword[phc_pkg::PRI_HI:phc_pkg::PRI_LO] = c_rsp_prio;
    hword[phc_pkg::CRF_BIT] = c_rsp_crf;
    hword[phc_pkg::SIZE_HI:phc_pkg::SIZE_LO] = c_rsp_size;
    if (has_subtype(c_rsp_class)) begin
      hword[phc_pkg::SUB_HI:phc_pkg::SUB_LO] = c_rsp_subtype;
    end
    case (c_rsp_class)
      phc_pkg::CLS_MSG: begin
        hword[phc_pkg::MLEN_HI:phc_pkg::MLEN_LO] = c_rsp_msg_len;
        hword[phc_pkg::MSEG_HI:phc_pkg::MSEG_LO] = c_rsp_msg_seg;
        hword[phc_pkg::MBOX_HI:phc_pkg::MBOX_LO] = c_rsp_mailbox;
        hword[phc_pkg::LTR_HI:0] = c_rsp_letter;
      end
      phc_pkg::CLS_RESP: begin
        hword[phc_pkg::TAG_HI:phc_pkg::TAG_LO] = c_rsp_tag;
        hword[phc_pkg::ERR_BIT] = c_rsp_status != phc_pkg::STATUS_DONE;
      end
      phc_pkg::CLS_DBELL: begin
        hword[phc_pkg::TAG_HI:phc_pkg::TAG_LO] = c_rsp_tag;
        hword[phc_pkg::INFO_HI:phc_pkg::INFO_LO] = c_rsp_addr[phc_pkg::INFO_HI:phc_pkg::INFO_LO];
      end
      default: begin
        hword[phc_pkg::TAG_HI:phc_pkg::TAG_LO] = c_rsp_tag;
        hword[phc_pkg::ADDR_HI:0] = c_rsp_addr;
      end
    endcase
  end

  always_comb begin
    st_nxt = st_r;
    mv_nxt = mv_r;
    ml_nxt = ml_r;
    md_nxt = md_r;
    mk_nxt = mk_r;
    rx_hdr_take = 1'b0;
    if (mv_r && m_rsp_tready) begin
      mv_nxt = 1'b0;
    end
    case (st_r)
      phc_pkg::RX_IDLE: begin
        if (c_rsp_valid && hrdy_r) begin
          rx_hdr_take = 1'b1;
          mv_nxt = 1'b1;
          md_nxt = hword;
          mk_nxt = 8'hFF;
          ml_nxt = !c_rsp_has_data;
          st_nxt = c_rsp_has_data ? phc_pkg::RX_DATA : phc_pkg::RX_HDR;
        end
      end
      phc_pkg::RX_HDR: begin
        if (!mv_nxt) begin
          st_nxt = phc_pkg::RX_IDLE;
        end
      end
      phc_pkg::RX_DATA: begin
        if (c_rsp_dvalid && drdy_r) begin
          mv_nxt = 1'b1;
          md_nxt = c_rsp_ddata;
          mk_nxt = c_rsp_dkeep;
          ml_nxt = c_rsp_dlast;
          if (c_rsp_dlast) begin
            st_nxt = phc_pkg::RX_HDR;
          end
        end
      end
      default: st_nxt = phc_pkg::RX_IDLE;
    endcase
    hrdy_nxt = st_nxt == phc_pkg::RX_IDLE && !mv_nxt;
    drdy_nxt = st_nxt == phc_pkg::RX_DATA && !mv_nxt;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      st_r <= phc_pkg::RX_IDLE;
      mv_r <= 1'b0;
      ml_r <= 1'b0;
      md_r <= 64'h0000000000000000;
      mk_r <= 8'h00;
      hrdy_r <= 1'b0;
      drdy_r <= 1'b0;
    end else begin
      st_r <= st_nxt;
      mv_r <= mv_nxt;
      ml_r <= ml_nxt;
      md_r <= md_nxt;
      mk_r <= mk_nxt;
      hrdy_r <= hrdy_nxt;
      drdy_r <= drdy_nxt;
    end
  end

  assign c_rsp_ready = hrdy_r;
  assign c_rsp_dready = drdy_r;
  assign m_rsp_tvalid = mv_r;
  assign m_rsp_tlast = ml_r;
  assign m_rsp_tdata = md_r;
  assign m_rsp_tkeep = mk_r;

  // ---------------- Checks ----------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  out_hold_a: assert property (mv_r && !m_rsp_tready |=> mv_r && $stable(md_r) && $stable(ml_r))
    else $error("response beat changed while stalled");
  req_hold_a: assert property (ov_r && !c_req_tready |=> ov_r && $stable(odata_r))
    else $error("request beat changed while stalled");
  hdr_last_a: assert property (c_rsp_valid && hrdy_r |=> mv_r && ml_r == !$past(c_rsp_has_data))
    else $error("header last flag wrong");
  hdr_tag_a: assert property (c_rsp_valid && hrdy_r && c_rsp_class == phc_pkg::CLS_RESP
    |=> md_r[63:56] == $past(c_rsp_tag) && md_r[55:52] == phc_pkg::CLS_RESP)
    else $error("tag or class misplaced");
  err_bit_a: assert property (c_rsp_valid && hrdy_r
    |=> md_r[35] == ($past(c_rsp_class) == phc_pkg::CLS_RESP && $past(c_rsp_status) != 4'h0))
    else $error("error bit does not follow status");
  // Judged against the enables at forwarding time; software may change them while stalled
  class_ok_a: assert property (ov_r && ohdr_r && !$past(ov_r)
    |-> class_ok(odata_r[55:52], $past(ctrl_r)))
    else $error("unsupported class forwarded");
  subtype_zero_a: assert property (ov_r && ohdr_r && !has_subtype(cls_r) |-> sub_r == 4'h0)
    else $error("subtype passed for class without one");
  data_after_hdr_a: assert property (c_rsp_valid && hrdy_r && c_rsp_has_data
    |=> st_r == phc_pkg::RX_DATA && !c_rsp_ready)
    else $error("new header taken inside payload");
  size_field_a: assert property (s_req_tvalid && rdy_r && !in_pkt_r && class_ok(in_cls, ctrl_r)
    |=> c_req_size == $past(s_req_tdata[43:36]))
    else $error("size field not decoded");
  cov_hdr_only_c: cover property (c_rsp_valid && hrdy_r && !c_rsp_has_data ##[1:4] mv_r && m_rsp_tready);
  cov_data_c: cover property (st_r == phc_pkg::RX_DATA ##[1:20] st_r == phc_pkg::RX_IDLE);
  cov_drop_c: cover property (tx_drop_done);
  cov_err_c: cover property (mv_r && md_r[35]);
endmodule

// ### inc/phc_pkg.sv
// Constants for the header-encoded packet codec
package phc_pkg;
  // Header field positions
  localparam int TAG_HI = 63;
  localparam int TAG_LO = 56;
  localparam int CLS_HI = 55;
  localparam int CLS_LO = 52;
  localparam int SUB_HI = 51;
  localparam int SUB_LO = 48;
  localparam int PRI_HI = 46;
  localparam int PRI_LO = 45;
  localparam int CRF_BIT = 44;
  localparam int SIZE_HI = 43;
  localparam int SIZE_LO = 36;
  localparam int ERR_BIT = 35;
  localparam int ADDR_HI = 33;
  localparam int MLEN_HI = 63;
  localparam int MLEN_LO = 60;
  localparam int MSEG_HI = 59;
  localparam int MSEG_LO = 56;
  localparam int MBOX_HI = 9;
  localparam int MBOX_LO = 4;
  localparam int LTR_HI = 1;
  localparam int INFO_HI = 31;
  localparam int INFO_LO = 16;
  // Transaction classes
  localparam logic [3:0] CLS_READ = 4'h2;
  localparam logic [3:0] CLS_WRITE = 4'h5;
  localparam logic [3:0] CLS_SWRITE = 4'h6;
  localparam logic [3:0] CLS_DBELL = 4'hA;
  localparam logic [3:0] CLS_MSG = 4'hB;
  localparam logic [3:0] CLS_RESP = 4'hD;
  // Response subtypes and status
  localparam logic [3:0] SUB_RESP_NODATA = 4'h0;
  localparam logic [3:0] SUB_RESP_DATA = 4'h8;
  localparam logic [3:0] SUB_RESP_MSG = 4'h1;
  localparam logic [3:0] STATUS_DONE = 4'h0;
  localparam logic [1:0] PRIO_ILLEGAL = 2'h3;
  // Register map
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_ERRCNT = 4'h4;
  localparam logic [3:0] OFS_PKTCNT = 4'h8;
  localparam logic [5:0] CTRL_RESET = 6'h3F;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_HDR = 3'b010,
    RX_DATA = 3'b100
  } phc_rx_state_t;
endpackage

// ### test/phc_core_model.sv
// Core-side partner model: takes request beats, issues received packets
`timescale 1ns/1ps
module phc_core_model (
  input wire logic aclk,
  input wire logic aresetn,
  output logic c_req_tready,
  output logic c_rsp_valid,
  input wire logic c_rsp_ready,
  output logic [7:0] c_rsp_tag,
  output logic [3:0] c_rsp_class,
  output logic [3:0] c_rsp_subtype,
  output logic [1:0] c_rsp_prio,
  output logic c_rsp_crf,
  output logic [7:0] c_rsp_size,
  output logic [3:0] c_rsp_status,
  output logic [33:0] c_rsp_addr,
  output logic [3:0] c_rsp_msg_len,
  output logic [3:0] c_rsp_msg_seg,
  output logic [5:0] c_rsp_mailbox,
  output logic [1:0] c_rsp_letter,
  output logic c_rsp_has_data,
  output logic [63:0] c_rsp_ddata,
  output logic [7:0] c_rsp_dkeep,
  output logic c_rsp_dlast,
  output logic c_rsp_dvalid,
  input wire logic c_rsp_dready
);
  logic slow;
  initial begin
    slow = 1'b0;
    {c_rsp_valid, c_rsp_dvalid, c_rsp_dlast, c_rsp_has_data, c_rsp_crf} = '0;
    {c_rsp_tag, c_rsp_class, c_rsp_subtype, c_rsp_prio, c_rsp_size, c_rsp_status} = '0;
    {c_rsp_addr, c_rsp_msg_len, c_rsp_msg_seg, c_rsp_mailbox, c_rsp_letter} = '0;
    {c_rsp_ddata, c_rsp_dkeep} = '0;
  end
  // Slow mode stalls every other cycle, so beats must hold
  always @(posedge aclk) begin
    c_req_tready <= aresetn & (slow ? ~c_req_tready : 1'b1);
  end
  task automatic rsp(input logic [7:0] tag, input logic [3:0] cls, input logic [3:0] sub,
      input logic [1:0] prio, input logic [3:0] st, input logic hd, input logic [63:0] d);
    @(posedge aclk);
    {c_rsp_tag, c_rsp_class, c_rsp_subtype, c_rsp_prio, c_rsp_crf} <= {tag, cls, sub, prio, hd};
    {c_rsp_size, c_rsp_status, c_rsp_has_data, c_rsp_valid} <= {8'h07, st, hd, 1'b1};
    c_rsp_addr <= 34'h2_AAAA_5555;
    {c_rsp_msg_len, c_rsp_msg_seg, c_rsp_mailbox, c_rsp_letter} <= {4'h3, 4'h1, 6'h2A, 2'h2};
    do @(posedge aclk); while (!c_rsp_ready);
    c_rsp_valid <= 1'b0;
    {c_rsp_tag, c_rsp_class, c_rsp_subtype, c_rsp_status} <= ~{tag, cls, sub, st};
    if (hd) begin
      {c_rsp_ddata, c_rsp_dkeep, c_rsp_dlast, c_rsp_dvalid} <= {d, 8'hFF, 2'b11};
      do @(posedge aclk); while (!c_rsp_dready);
      {c_rsp_ddata, c_rsp_dlast, c_rsp_dvalid} <= {~d, 2'b00};
    end
  endtask
endmodule

// ### test/test_packet_header_format_codec.sv
// Self-checking bench for the header-encoded packet codec
`timescale 1ns/1ps
module test_packet_header_format_codec;
  logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata, rd;
  logic [3:0] s_axi_wstrb, c_req_class, c_req_subtype, c_rsp_class, c_rsp_subtype;
  logic [3:0] c_rsp_status, c_rsp_msg_len, c_rsp_msg_seg;
  logic [1:0] s_axi_bresp, s_axi_rresp, rr, c_req_prio, c_rsp_prio, c_rsp_letter;
  logic [63:0] s_req_tdata, c_req_tdata, c_rsp_ddata, m_rsp_tdata;
  logic [7:0] s_req_tkeep, c_req_tkeep, c_rsp_dkeep, m_rsp_tkeep, c_req_tag, c_req_size;
  logic [7:0] c_rsp_tag, c_rsp_size;
  logic s_req_tlast, s_req_tvalid, s_req_tready, c_req_tlast, c_req_header, c_req_tvalid;
  logic c_req_tready, c_req_crf, c_rsp_valid, c_rsp_ready, c_rsp_dlast, c_rsp_dvalid;
  logic c_rsp_dready, m_rsp_tlast, m_rsp_tvalid, m_rsp_tready, c_rsp_crf, c_rsp_has_data;
  logic [33:0] c_req_addr, c_rsp_addr;
  logic [5:0] c_rsp_mailbox;
  logic [79:0] cq[$];
  logic [79:0] mq[$];
  int n_errors = 0;
  int samples_checked = 0;
  phc_codec i_phc_codec (.*);
  phc_core_model i_phc_core_model (.*);
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  // Response sink stalls every other cycle
  always @(posedge aclk) begin
    m_rsp_tready <= aresetn & ~m_rsp_tready;
    if (c_req_tvalid && c_req_tready) cq.push_back({c_req_header, c_req_tlast, c_req_tkeep, c_req_tdata});
    if (m_rsp_tvalid && m_rsp_tready) mq.push_back({m_rsp_tkeep, m_rsp_tlast, m_rsp_tdata});
  end
  task automatic chk(input string what, input logic [79:0] got, input logic [79:0] exp);
    samples_checked++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask
  task automatic axi_wr(input logic [31:0] a, input logic [31:0] d);
    {s_axi_awaddr, s_axi_wdata} <= {a, d};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    rr = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic axi_rd(input logic [31:0] a);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    {rr, rd} = {s_axi_rresp, s_axi_rdata};
    s_axi_rready <= 1'b0;
    @(posedge aclk);
  endtask
  task automatic snd(input logic [63:0] d, input logic [7:0] k, input logic l);
    {s_req_tdata, s_req_tkeep, s_req_tlast, s_req_tvalid} <= {d, k, l, 1'b1};
    do @(posedge aclk); while (!s_req_tready);
    {s_req_tdata, s_req_tvalid} <= {~d, 1'b0};
    @(posedge aclk);
  endtask
  task automatic pop(input bit m, input logic [79:0] e);
    int n;
    n = 0;
    while ((m ? mq.size() : cq.size()) == 0 && n < 40) begin
      @(posedge aclk);
      n++;
    end
    if (m) chk("m_rsp beat", mq.size() ? mq.pop_front() : 'x, e);
    else chk("c_req beat", cq.size() ? cq.pop_front() : 'x, e);
  endtask
  task automatic t_regs();
    axi_rd({28'h0, phc_pkg::OFS_CTRL});
    chk("ctrl reset", {rr, rd}, {phc_pkg::RESP_OKAY, 32'h0000_003F});
    axi_rd(32'hC);
    chk("unmapped rd", {rr, rd}, {phc_pkg::RESP_SLVERR, 32'h0});
    axi_wr(32'hC, 32'h1);
    chk("unmapped wr", rr, phc_pkg::RESP_SLVERR);
    axi_wr(32'h4, 32'hFFFF_FFFF);
    axi_rd(32'h4);
    chk("errcnt ro", rd, 32'h0);
    $display("register test done");
  endtask
  task automatic t_req();
    logic [63:0] h;
    h = {8'hA5, 4'h2, 4'h4, 1'b0, 2'h1, 1'b1, 8'h07, 2'b00, 34'h1_2345_6788};
    snd(h, 8'hFF, 1'b1);
    pop(0, {2'b11, 8'hFF, h});
    chk("fields", {c_req_tag, c_req_class, c_req_subtype, c_req_prio, c_req_crf, c_req_size,
      c_req_addr}, {8'hA5, 4'h2, 4'h4, 2'h1, 1'b1, 8'h07, 34'h1_2345_6788});
    i_phc_core_model.slow <= 1'b1;
    // Subtype set on purpose: the decoded field must come out zero for this class
    h = {8'h00, 4'h6, 4'h3, 1'b0, 2'h2, 1'b0, 8'h0B, 2'b00, 34'h0_0000_1000};
    snd(h, 8'hFF, 1'b0);
    snd(64'h1111_2222_3333_4444, 8'hFF, 1'b0);
    snd(64'h5555_6666_7777_8888, 8'h0F, 1'b1);
    pop(0, {2'b10, 8'hFF, h});
    pop(0, {2'b00, 8'hFF, 64'h1111_2222_3333_4444});
    pop(0, {2'b01, 8'h0F, 64'h5555_6666_7777_8888});
    chk("sw fields", {c_req_class, c_req_subtype, c_req_size}, {4'h6, 4'h0, 8'h0B});
    i_phc_core_model.slow <= 1'b0;
    $display("request test done");
  endtask
  task automatic t_drop();
    snd({8'h11, 4'h8, 52'h0}, 8'hFF, 1'b0);
    snd(64'h0123_4567_89AB_CDEF, 8'hFF, 1'b1);
    axi_wr(32'h0, 32'h3E);
    axi_rd(32'h0);
    chk("ctrl", rd, 32'h0000_003E);
    snd({8'h12, 4'h2, 4'h4, 48'h0}, 8'hFF, 1'b1);
    axi_rd(32'h4);
    chk("errcnt", rd, 32'h0000_0002);
    chk("dropped", cq.size(), 0);
    axi_wr(32'h0, 32'h3F);
    snd({8'h13, 4'h2, 4'h4, 1'b0, 2'h3, 45'h0}, 8'hFF, 1'b1);
    pop(0, {2'b11, 8'hFF, 8'h13, 4'h2, 4'h4, 1'b0, 2'h3, 45'h0});
    snd({8'hA5, 4'hD, 4'h0, 1'b0, 2'h2, 45'h0}, 8'hFF, 1'b1);
    pop(0, {2'b11, 8'hFF, 8'hA5, 4'hD, 4'h0, 1'b0, 2'h2, 45'h0});
    axi_rd(32'h4);
    chk("errcnt prio", rd, 32'h0001_0002);
    $display("drop test done");
  endtask
  task automatic t_rsp();
    i_phc_core_model.rsp(8'h3C, 4'hD, 4'h8, 2'h2, 4'h3, 1'b1, 64'hFEDC_BA98_7654_3210);
    pop(1, {8'hFF, 1'b0, 8'h3C, 4'hD, 4'h8, 1'b0, 2'h2, 1'b1, 8'h07, 1'b1, 35'h0});
    pop(1, {8'hFF, 1'b1, 64'hFEDC_BA98_7654_3210});
    i_phc_core_model.rsp(8'h01, 4'hD, 4'h0, 2'h3, 4'h0, 1'b0, 64'h0);
    pop(1, {8'hFF, 1'b1, 8'h01, 4'hD, 4'h0, 1'b0, 2'h3, 1'b0, 8'h07, 1'b0, 35'h0});
    i_phc_core_model.rsp(8'h77, 4'hB, 4'h5, 2'h1, 4'h7, 1'b1, 64'h5A5A_0F0F_A5A5_F0F0);
    pop(1, {8'hFF, 1'b0, 4'h3, 4'h1, 4'hB, 4'h0, 1'b0, 2'h1, 1'b1, 8'h07, 1'b0, 25'h0,
      6'h2A, 2'h0, 2'h2});
    pop(1, {8'hFF, 1'b1, 64'h5A5A_0F0F_A5A5_F0F0});
    i_phc_core_model.rsp(8'h44, 4'hA, 4'h5, 2'h0, 4'h0, 1'b0, 64'h0);
    pop(1, {8'hFF, 1'b1, 8'h44, 4'hA, 4'h0, 1'b0, 2'h0, 1'b0, 8'h07, 1'b0, 3'h0, 16'hAAAA,
      16'h0});
    i_phc_core_model.rsp(8'h55, 4'h5, 4'h4, 2'h1, 4'h2, 1'b0, 64'h0);
    pop(1, {8'hFF, 1'b1, 8'h55, 4'h5, 4'h4, 1'b0, 2'h1, 1'b0, 8'h07, 2'b00,
      34'h2_AAAA_5555});
    axi_rd(32'h8);
    chk("pktcnt", rd, 32'h0005_0004);
    $display("response test done");
  endtask
  initial begin
    #200000;
    n_errors++;
    end_sim();
  end
  initial begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
    {s_req_tdata, s_req_tkeep, s_req_tlast, s_req_tvalid} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    repeat (2) @(posedge aclk);
    t_regs();
    t_req();
    t_drop();
    t_rsp();
    end_sim();
  end
endmodule
